// ===== src/twi_cfg_pkg.sv
// Shared constants and state types for the two-wire configuration port.
// Assumes every user of it runs on the 200 MHz sys_clk.
package twi_cfg_pkg;

  // ----------
  // Bus address and timing
  // ----------
  localparam logic [6:0] DEV_ADDR = 7'h4C;    // Target address 1001100
  localparam int SYS_NS = 5;                  // sys_clk period in ns
  localparam int XTAL_NS = 40;                // Reference crystal period, 25 MHz
  localparam int FILT_XTAL = 3;               // Deglitch length in crystal periods
  localparam int FILT_NS = FILT_XTAL * XTAL_NS; // 120 ns
  // Least time, so round up to whole sys_clk cycles
  localparam logic [4:0] FILT_CYC = 5'((FILT_NS + SYS_NS - 1) / SYS_NS);
  localparam int HOST_QTR_NS = 625;           // Quarter of the host clock period
  localparam logic [7:0] HOST_QTR_CYC = 8'(HOST_QTR_NS / SYS_NS);

  // ----------
  // Reset values and byte length
  // ----------
  localparam logic [7:0] PTR_RST = 8'h00;     // Register pointer after reset
  localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Data bits before the ack slot

  // ----------
  // State types
  // ----------
  typedef enum logic [3:0] {
    D_IDLE = 4'h0, D_ADDR = 4'h1, D_ADDR_ACK = 4'h2, D_PTR = 4'h3,
    D_PTR_ACK = 4'h4, D_WDATA = 4'h5, D_WDATA_ACK = 4'h6, D_RDATA = 4'h7,
    D_RACK = 4'h8
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_START = 2'h1, H_BYTE = 2'h2, H_STOP = 2'h3
  } host_state_t;

  typedef enum logic [2:0] {
    ST_ADDRW = 3'h0, ST_PTR = 3'h1, ST_WDATA = 3'h2, ST_ADDRR = 3'h3,
    ST_RDATA = 3'h4
  } host_stage_t;

endpackage : twi_cfg_pkg

// ===== src/twi_cfg_if.sv
// Open-drain two-wire link between the host end and the target end.
// Assumes both ends drive only enables; a line is low if anyone enables.
`timescale 1ns/1ps
`default_nettype none
interface twi_cfg_if;
  // Host drive of the clock line
  logic scl_host_o;
  logic scl_host_oe;
  // Host and target drive of the data line
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  // Resolved wired-AND levels, high when released
  logic scl;
  logic sda;
  assign scl = ~scl_host_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport host (output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe, input sda);
  modport dev (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface : twi_cfg_if
`default_nettype wire

// ===== src/twi_cfg_target.sv
// Target end of the two-wire configuration port.
// Assumes a register file outside returns rd_data for reg_ptr combinationally.
// Operation
// - Host alone drives the clock line
// - Data line only pulled low or released
// - Answer only address 1001100
// - Idle bus leaves both lines high
// - Host starts with data falling, clock high
// - Ignore everything until a start
// - Host sends address then direction bit
// - Acknowledge own address in ack clock
// - One or more bytes follow the address
// - Stop ends transfer, back to idle
// - Repeated start ends transfer, takes address
// - Data stable while clock is high
// - Deglitch clock over three crystal periods
// - Capture write bits on filtered rising edge
// - Change read data after filtered falling edge
// - First written byte sets register pointer
// - Store written byte, then advance pointer
// - Return byte at pointer, then advance
`timescale 1ns/1ps
`default_nettype none
module twi_cfg_target
  import twi_cfg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Two-wire link
  twi_cfg_if.dev link,
  // Register file side
  output logic [7:0] reg_ptr,
  input wire logic [7:0] rd_data,
  output logic wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic busy
);

  // ----------
  // Line conditioning
  // ----------
  logic [1:0] line_s1;        // First sync stage, {sda, scl}
  logic [1:0] line_s2;        // Second sync stage
  logic [1:0] line_f;         // Filtered and delayed lines
  logic [1:0] line_d;         // Filtered lines one cycle ago
  logic [4:0] filt_cnt [2];   // Stability counters per line

  // Both lines see the same delay so start and stop keep their meaning
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      line_s1 <= 2'h3;
      line_s2 <= 2'h3;
    end else begin
      line_s1 <= {link.sda, link.scl};
      line_s2 <= line_s1;
    end
  end

  // A level passes only once stable for the whole filter length
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      line_f <= 2'h3;
      line_d <= 2'h3;
      filt_cnt[0] <= 5'h00;
      filt_cnt[1] <= 5'h00;
    end else begin
      line_d <= line_f;
      for (int i = 0; i < 2; i++) begin
        if (line_s2[i] == line_f[i]) begin
          filt_cnt[i] <= 5'h00; // Glitch gone, restart
        end else if (filt_cnt[i] == FILT_CYC - 5'h01) begin
          line_f[i] <= line_s2[i];
          filt_cnt[i] <= 5'h00;
        end else begin
          filt_cnt[i] <= filt_cnt[i] + 5'h01;
        end
      end
    end
  end

  // ----------
  // Bus events
  // ----------
  wire scl_f = line_f[0];
  wire sda_f = line_f[1];
  wire scl_rise = scl_f & ~line_d[0];
  wire scl_fall = ~scl_f & line_d[0];
  // Data edges while the clock stays high
  wire start_cond = scl_f & line_d[0] & line_d[1] & ~sda_f;
  wire stop_cond = scl_f & line_d[0] & ~line_d[1] & sda_f;

  // ----------
  // Protocol state
  // ----------
  dev_state_t state;          // Current protocol step
  dev_state_t next_state;
  logic [3:0] bit_cnt;        // Bits handled in the current byte
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;          // Receive or transmit shifter
  logic [7:0] next_shift;
  logic [7:0] next_ptr;
  logic dir_read;             // Direction bit of the address byte
  logic next_dir_read;
  logic host_ack;             // Host acked the last read byte
  logic next_host_ack;
  logic sda_oe;               // Pull the data line low
  logic next_sda_oe;
  logic sda_zero;             // Constant low drive value
  logic next_wr;

  wire byte_done = scl_fall & (bit_cnt == BITS_PER_BYTE);
  wire addr_hit = (shift[7:1] == DEV_ADDR);

  // Next-state decode; stop and start override any step
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_ptr = reg_ptr;
    next_dir_read = dir_read;
    next_host_ack = host_ack;
    next_sda_oe = sda_oe;
    next_wr = 1'b0;
    if (stop_cond) begin
      next_state = D_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_cond) begin
      next_state = D_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        // Waiting for a start, nothing else counts
        D_IDLE: begin
          next_sda_oe = 1'b0;
        end
        // Receiving a byte from the host
        D_ADDR, D_PTR, D_WDATA: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (byte_done) begin
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b1; // Ack by pulling low
            if (state == D_ADDR) begin
              next_dir_read = shift[0];
              next_state = addr_hit ? D_ADDR_ACK : D_IDLE;
              next_sda_oe = addr_hit;
            end else if (state == D_PTR) begin
              next_ptr = shift;
              next_state = D_PTR_ACK;
            end else begin
              next_wr = 1'b1; // Store at pointer
              next_ptr = reg_ptr + 8'h01;
              next_state = D_WDATA_ACK;
            end
          end
        end
        // Ack slots end on the falling edge
        D_ADDR_ACK, D_PTR_ACK, D_WDATA_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_bit_cnt = 4'h0;
            if (state == D_ADDR_ACK && dir_read) begin
              next_shift = rd_data;
              next_sda_oe = ~rd_data[7];
              next_bit_cnt = 4'h1;
              next_state = D_RDATA;
            end else begin
              next_state = (state == D_ADDR_ACK) ? D_PTR : D_WDATA;
            end
          end
        end
        // Sending a byte, bits move only after a falling edge
        D_RDATA: begin
          if (byte_done) begin
            next_sda_oe = 1'b0; // Release for the host ack
            next_ptr = reg_ptr + 8'h01;
            next_state = D_RACK;
          end else if (scl_fall) begin
            next_shift = {shift[6:0], 1'b0};
            next_sda_oe = ~shift[6];
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end
        // Host ack decides whether another byte follows
        D_RACK: begin
          if (scl_rise) begin
            next_host_ack = ~sda_f;
          end else if (scl_fall) begin
            if (host_ack) begin
              next_shift = rd_data; // Next register
              next_sda_oe = ~rd_data[7];
              next_bit_cnt = 4'h1;
              next_state = D_RDATA;
            end else begin
              next_state = D_IDLE; // No ack, wait for stop
            end
          end
        end
        default: begin
          next_state = D_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= D_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      reg_ptr <= PTR_RST;
      dir_read <= 1'b0;
      host_ack <= 1'b0;
      sda_oe <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      reg_ptr <= next_ptr;
      dir_read <= next_dir_read;
      host_ack <= next_host_ack;
      sda_oe <= next_sda_oe;
      busy <= (next_state != D_IDLE);
    end
  end

  // Write port; the address is the pointer before it advanced
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_strobe <= 1'b0;
      wr_addr <= PTR_RST;
      wr_data <= 8'h00;
      sda_zero <= 1'b0;
    end else begin
      wr_strobe <= next_wr;
      sda_zero <= 1'b0;     // Open drain never drives high
      if (next_wr) begin
        wr_addr <= reg_ptr;
        wr_data <= shift;
      end
    end
  end

  // Only the data line is driven; the clock is never touched
  assign link.sda_dev_o = sda_zero;
  assign link.sda_dev_oe = sda_oe;

endmodule : twi_cfg_target
`default_nettype wire

// ===== src/twi_cfg_host.sv
// Host end of the two-wire configuration port: makes the clock by a divider.
// Assumes the user holds the request fields stable while ready is low.
`timescale 1ns/1ps
`default_nettype none
module twi_cfg_host
  import twi_cfg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Two-wire link
  twi_cfg_if.host link,
  // Request
  input wire logic req,
  input wire logic req_read,
  input wire logic [7:0] req_ptr,
  input wire logic [7:0] req_len,
  output logic ready,
  // Write data, next byte taken on wr_take
  input wire logic [7:0] wr_data,
  output logic wr_take,
  // Read data and completion
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nacked
);

  // ----------
  // Data line sampling and clock divider
  // ----------
  logic sda_s1;               // First sync stage
  logic sda_s2;               // Second sync stage
  logic [7:0] qcnt;           // Cycles within a quarter period
  logic [1:0] phase;          // Quarter of the bit period
  host_state_t state;         // Sequencer step, read by the divider

  wire tick = (qcnt == HOST_QTR_CYC - 8'h01);

  // Divider runs only while a transfer is active
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      qcnt <= 8'h00;
      phase <= 2'h0;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      qcnt <= (state == H_IDLE || tick) ? 8'h00 : qcnt + 8'h01;
      if (state == H_IDLE) begin
        phase <= 2'h0;
      end else if (tick) begin
        phase <= phase + 2'h1;
      end
    end
  end

  // ----------
  // Transfer sequencer
  // ----------
  host_stage_t stage;         // Which byte of the transfer is on the bus
  logic read_op;              // Latched request direction
  logic [7:0] ptr;            // Latched register pointer
  logic [7:0] len;            // Data bytes still to move
  logic [7:0] tx;             // Transmit shifter
  logic [7:0] rx;             // Receive shifter
  logic [3:0] bit_cnt;        // Bit within the 9-bit slot
  logic ack_bit;              // Level seen in the ack slot
  logic scl_oe;               // Pull the clock low
  logic sda_oe;               // Pull the data line low
  logic drive_zero;           // Constant low drive value

  wire tx_mode = (stage != ST_RDATA);
  wire last_byte = (len == 8'h01);
  wire data_slot = (bit_cnt < BITS_PER_BYTE);
  // Ack every read byte but the last one
  wire slot_sda_oe = data_slot ? (tx_mode & ~tx[7]) : (~tx_mode & ~last_byte);

  // Quarter phases: 0 set data, 1 release clock, 2 sample, 3 clock low
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= H_IDLE;
      stage <= ST_ADDRW;
      read_op <= 1'b0;
      ptr <= PTR_RST;
      len <= 8'h00;
      tx <= 8'h00;
      rx <= 8'h00;
      bit_cnt <= 4'h0;
      ack_bit <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      drive_zero <= 1'b0;
      ready <= 1'b0;
      wr_take <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nacked <= 1'b0;
    end else begin
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      drive_zero <= 1'b0;
      ready <= (state == H_IDLE) && !req;
      case (state)
        // Idle bus: both lines released
        H_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          if (req) begin
            state <= H_START;
            stage <= ST_ADDRW;
            read_op <= req_read;
            ptr <= req_ptr;
            len <= req_len;
            nacked <= 1'b0;
          end
        end
        // Start, or repeated start from a low clock
        H_START: begin
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default: begin
                scl_oe <= 1'b1;
                tx <= {DEV_ADDR, stage == ST_ADDRR};
                bit_cnt <= 4'h0;
                state <= H_BYTE;
              end
            endcase
          end
        end
        // Eight data bits and the ack slot
        H_BYTE: begin
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= slot_sda_oe;
              2'h1: scl_oe <= 1'b0;
              2'h2: begin
                if (data_slot) begin
                  rx <= {rx[6:0], sda_s2};
                end else begin
                  ack_bit <= sda_s2;
                end
              end
              default: begin
                scl_oe <= 1'b1;
                bit_cnt <= bit_cnt + 4'h1;
                tx <= {tx[6:0], 1'b0};
                if (!data_slot) begin
                  bit_cnt <= 4'h0;
                  if (tx_mode && ack_bit) begin
                    nacked <= 1'b1;
                    state <= H_STOP;
                  end else begin
                    case (stage)
                      ST_ADDRW: begin
                        stage <= ST_PTR;
                        tx <= ptr;
                      end
                      ST_PTR: begin
                        if (read_op) begin
                          stage <= ST_ADDRR;
                          state <= H_START;
                        end else begin
                          stage <= ST_WDATA;
                          tx <= wr_data;
                          wr_take <= 1'b1;
                        end
                      end
                      ST_WDATA: begin
                        len <= len - 8'h01;
                        tx <= wr_data;
                        wr_take <= ~last_byte;
                        if (last_byte) begin
                          state <= H_STOP;
                        end
                      end
                      ST_ADDRR: stage <= ST_RDATA;
                      default: begin
                        rd_data <= rx;
                        rd_valid <= 1'b1;
                        len <= len - 8'h01;
                        if (last_byte) begin
                          state <= H_STOP;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        // Stop: data rises while the clock is high
        default: begin
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: begin
                done <= 1'b1;
                state <= H_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Open-drain drive of both lines
  assign link.scl_host_o = drive_zero;
  assign link.scl_host_oe = scl_oe;
  assign link.sda_host_o = drive_zero;
  assign link.sda_host_oe = sda_oe;

endmodule : twi_cfg_host
`default_nettype wire

// ===== tb/twi_cfg_properties.sv
// Checker for the link between the host end and the target end.
// Assumes it watches the first link only, all on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module twi_cfg_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link drives and resolved levels
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  // ----------
  // Raw framing, seen without any filter
  // ----------
  logic scl_q; // Clock one cycle ago
  logic sda_q; // Data one cycle ago
  logic idle; // No transfer open
  logic rd_dir; // Direction of the open transfer
  logic [3:0] bit_cnt; // Bits of the current byte
  logic [7:0] shreg; // Byte being shifted in
  logic [7:0] byte_idx; // Bytes since the last start
  logic [5:0] low_cnt; // Cycles the clock has stayed low
  wire logic scl_rise = scl & ~scl_q;
  wire logic start_ev = scl & scl_q & sda_q & ~sda;
  wire logic stop_ev = scl & scl_q & ~sda_q & sda;
  wire logic ack_slot = scl_rise & (bit_cnt == 4'h8);
  // Edge history; low count saturates so it never wraps
  always_ff @(posedge sys_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    low_cnt <= scl ? 6'h00 : (low_cnt == 6'h3F ? low_cnt : low_cnt + 6'h01);
  end
  // Start or stop opens a fresh byte count
  always_ff @(posedge sys_clk) begin
    if (!reset_n || start_ev || stop_ev) begin
      bit_cnt <= 4'h0;
      byte_idx <= 8'h00;
    end else if (ack_slot) begin
      bit_cnt <= 4'h0;
      byte_idx <= byte_idx + 8'h01;
    end else if (scl_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end
  // Data bits, direction and bus state
  always_ff @(posedge sys_clk) begin
    if (scl_rise && !ack_slot) shreg <= {shreg[6:0], sda};
    if (ack_slot && byte_idx == 8'h00) rd_dir <= shreg[0];
    if (!reset_n || stop_ev) idle <= 1'b1;
    else if (start_ev) idle <= 1'b0;
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_lines_free;
    !scl_host_oe && !sda_host_oe && !sda_dev_oe;
  endsequence
  sequence s_wr_ack;
    ack_slot && byte_idx != 8'h00 && !rd_dir;
  endsequence
  sequence s_rd_ack;
    ack_slot && byte_idx != 8'h00 && rd_dir;
  endsequence
  property p_reset_free;
    $rose(reset_n) |-> s_lines_free ##1 s_lines_free;
  endproperty
  property p_drive_zero;
    !scl_host_o && !sda_host_o && !sda_dev_o;
  endproperty
  // The target may only move its line 20 to 34 cycles into a clock-low phase
  property p_dev_timing;
    $changed(sda_dev_oe) |-> !scl && low_cnt >= 6'h14 && low_cnt <= 6'h22;
  endproperty
  property p_addr_ack;
    ack_slot && byte_idx == 8'h00 && shreg[7:1] == 7'h4C |-> sda_dev_oe;
  endproperty
  property p_write_ack;
    s_wr_ack |-> sda_dev_oe ##1 sda_dev_oe;
  endproperty
  property p_read_release;
    s_rd_ack |-> !sda_dev_oe;
  endproperty
  property p_bit_quiet;
    scl_rise && bit_cnt != 4'h8 && (byte_idx == 8'h00 || !rd_dir) |-> !sda_dev_oe;
  endproperty
  property p_idle_quiet;
    idle |-> !sda_dev_oe;
  endproperty
  a_reset_free: assert property (p_reset_free) else $error("lines held after reset");
  a_drive_zero: assert property (p_drive_zero) else $error("a line driven high");
  a_dev_timing: assert property (p_dev_timing) else $error("target data moved early");
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
  a_write_ack: assert property (p_write_ack) else $error("written byte not acked");
  a_read_release: assert property (p_read_release) else $error("host ack blocked");
  a_bit_quiet: assert property (p_bit_quiet) else $error("target drove host bit");
  a_idle_quiet: assert property (p_idle_quiet) else $error("target drove idle bus");
endmodule : twi_cfg_properties
`default_nettype wire

// ===== tb/tb_serial_config_register_port.sv
// Bench: host end to target end, and a bench-driven second target.
// Assumes a register model beside the target that answers at once.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_config_register_port;
  // ----------
  // Clock, reset, links and user sides
  // ----------
  logic sys_clk = 1'b0; // 200 MHz
  logic reset_n = 1'b0; // Synchronous, active low
  twi_cfg_if link(); // Host end to target end
  twi_cfg_if bb(); // Bench to the second target
  logic h_req = 1'b0;
  logic h_read = 1'b0;
  logic [7:0] h_ptr = 8'h00;
  logic [7:0] h_len = 8'h01;
  logic [7:0] h_wdata = 8'h00;
  logic h_ready, h_take, h_rvalid, h_done, h_nacked, t_wstb, t_busy, b_busy, ack;
  logic [7:0] h_rdata, t_ptr, t_waddr, t_wdata;
  logic [7:0] regs [256]; // Register file model
  wire logic [7:0] t_rd = regs[t_ptr]; // Combinational read port
  int miscompares = 0;
  int total_checks = 0;
  int widx = 0; // Write byte now offered to the host
  logic [7:0] wdat [3] = '{8'hA5, 8'h3C, 8'h81};
  logic [7:0] wire_q [$], rq [$], exp_q [$];
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  twi_cfg_host twi_cfg_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link.host),
    .req(h_req), .req_read(h_read), .req_ptr(h_ptr), .req_len(h_len), .ready(h_ready),
    .wr_data(h_wdata), .wr_take(h_take), .rd_data(h_rdata), .rd_valid(h_rvalid),
    .done(h_done), .nacked(h_nacked));
  twi_cfg_target twi_cfg_target_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link.dev),
    .reg_ptr(t_ptr), .rd_data(t_rd), .wr_strobe(t_wstb), .wr_addr(t_waddr),
    .wr_data(t_wdata), .busy(t_busy));
  twi_cfg_target bb_twi_cfg_target_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(bb.dev), .reg_ptr(), .rd_data(8'h00), .wr_strobe(), .wr_addr(), .wr_data(),
    .busy(b_busy));
  twi_cfg_properties twi_cfg_properties_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .scl_host_o(link.scl_host_o), .scl_host_oe(link.scl_host_oe),
    .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));
  // ----------
  // Register file, user data and wire monitor
  // ----------
  always @(posedge sys_clk) begin
    if (t_wstb) regs[t_waddr] <= t_wdata;
  end
  // Next write byte is offered once the host took the current one
  always @(negedge sys_clk) begin
    if (h_rvalid) rq.push_back(h_rdata);
    if (h_take && widx < 2) begin
      widx = widx + 1;
      h_wdata = wdat[widx];
    end
  end
  logic scl_d = 1'b1;
  logic sda_d = 1'b1;
  logic [7:0] mon_sh = 8'h00;
  int mon_n = 0;
  // Bytes in wire order, ack bits dropped
  always @(posedge sys_clk) begin
    scl_d <= link.scl;
    sda_d <= link.sda;
    if (link.scl && scl_d && sda_d && !link.sda) mon_n = 0;
    else if (link.scl && !scl_d) begin
      if (mon_n == 8) mon_n = 0;
      else begin
        mon_sh = {mon_sh[6:0], link.sda};
        mon_n++;
        if (mon_n == 8) wire_q.push_back(mon_sh);
      end
    end
  end
  // ----------
  // Tasks
  // ----------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk_wire();
    chk("wire byte count", 8'(wire_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) chk("wire byte", wire_q[i], exp_q[i]);
  endtask : chk_wire
  // One host transfer; a hang counts as a mismatch and ends the run
  task automatic xfer(input logic rd, input logic [7:0] ptr, input int n);
    int k;
    wire_q.delete();
    rq.delete();
    h_read = rd;
    h_ptr = ptr;
    h_len = 8'(n);
    widx = 0;
    h_wdata = wdat[0];
    for (k = 0; h_ready !== 1'b1 && k < 40000; k++) @(negedge sys_clk);
    h_req = 1'b1;
    @(negedge sys_clk);
    h_req = 1'b0;
    while (h_done !== 1'b1 && k < 40000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 40000) begin
      miscompares++;
      summarize();
    end
  endtask : xfer
  // Bench-made bit; optional 100 ns spikes in the low phase must be lost
  task automatic bb_bit(input logic b, input logic glitch, output logic s);
    repeat (40) @(negedge sys_clk);
    bb.sda_host_oe = ~b;
    repeat (20) @(negedge sys_clk);
    repeat (glitch ? 4 : 0) begin
      repeat (20) @(negedge sys_clk);
      bb.scl_host_oe = ~bb.scl_host_oe;
    end
    repeat (40) @(negedge sys_clk);
    bb.scl_host_oe = 1'b0;
    repeat (60) @(negedge sys_clk);
    s = bb.sda;
    bb.scl_host_oe = 1'b1;
  endtask : bb_bit
  task automatic bb_byte(input logic [7:0] v, input logic glitch, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bb_bit(v[i], glitch, s);
    bb_bit(1'b1, glitch, s);
    a = ~s;
  endtask : bb_byte
  // Start or stop, entered with the clock low or the bus idle
  task automatic bb_cond(input logic is_start);
    repeat (40) @(negedge sys_clk);
    bb.sda_host_oe = ~is_start;
    repeat (40) @(negedge sys_clk);
    bb.scl_host_oe = 1'b0;
    repeat (60) @(negedge sys_clk);
    bb.sda_host_oe = is_start;
    repeat (60) @(negedge sys_clk);
    bb.scl_host_oe = is_start;
  endtask : bb_cond
  // ----------
  // Main sequence
  // ----------
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    bb.scl_host_o = 1'b0;
    bb.sda_host_o = 1'b0;
    bb.scl_host_oe = 1'b0;
    bb.sda_host_oe = 1'b0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk("pointer after reset", t_ptr, 8'h00);
    // Burst write across the top of the pointer range
    xfer(1'b0, 8'hFE, 3);
    exp_q = {8'h98, 8'hFE, wdat[0], wdat[1], wdat[2]};
    chk_wire();
    for (int i = 0; i < 3; i++) chk("stored", regs[8'hFE + 8'(i)], wdat[i]);
    chk("pointer after write", t_ptr, 8'h01);
    chk("host saw nack", {7'h00, h_nacked}, 8'h00);
    $display("Test burst write done");
    // Read back at once: pointer, repeated start, read
    xfer(1'b1, 8'hFE, 3);
    exp_q = {8'h98, 8'hFE, 8'h99, wdat[0], wdat[1], wdat[2]};
    chk_wire();
    foreach (wdat[i]) chk("read byte", rq[i], wdat[i]);
    chk("pointer after read", t_ptr, 8'h01);
    chk("busy after stop", {7'h00, t_busy}, 8'h00);
    $display("Test burst read done");
    // Second target: clocking before any start, spikes, other address
    bb.scl_host_oe = 1'b1;
    bb_byte(8'h98, 1'b0, ack);
    chk("ack before start", {7'h00, ack}, 8'h00);
    bb_cond(1'b1);
    bb_byte(8'h98, 1'b1, ack);
    chk("ack through spikes", {7'h00, ack}, 8'h01);
    bb_cond(1'b0);
    chk("fault busy after stop", {7'h00, b_busy}, 8'h00);
    bb_cond(1'b1);
    bb_byte(8'h9A, 1'b0, ack);
    chk("ack other address", {7'h00, ack}, 8'h00);
    bb_cond(1'b0);
    $display("Test faulty traffic done");
    summarize();
  end
endmodule : tb_serial_config_register_port
`default_nettype wire
